// >>> bench/dosm_master.sv
`timescale 1ns/1ps
`default_nettype none
// fieldbus controller model, one bus transfer of each kind at a time
module dosm_master (
	input wire logic clk_i,
	output logic [7:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [7:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	// idle bus at time zero
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end
	// each channel held until its own ready, response taken at bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		{aw, w, b} = 3'h7;
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		while (aw | w | b) begin
			@(posedge clk_i);
			if (aw && awready_i) begin
				aw = 1'b0;
				awvalid_o <= 1'b0;
			end
			if (w && wready_i) begin
				w = 1'b0;
				wvalid_o <= 1'b0;
			end
			if (b && !aw && !w && bvalid_i) begin
				b = 1'b0;
				r = bresp_i;
				bready_o <= 1'b0;
			end
		end
	endtask
	// read: rready held high until rvalid is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ar, rr;
		{ar, rr} = 2'h3;
		@(posedge clk_i);
		araddr_o <= a;
		{arvalid_o, rready_o} <= 2'h3;
		while (ar | rr) begin
			@(posedge clk_i);
			if (ar && arready_i) begin
				ar = 1'b0;
				arvalid_o <= 1'b0;
			end else if (!ar && rvalid_i) begin
				rr = 1'b0;
				d = rdata_i;
				rready_o <= 1'b0;
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> bench/dosm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dosm_top_tb;
	import dosm_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic pwr_ok = 1'b0; // power stage supply pin
	logic err = 1'b0; // error pin
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	logic [1:0] bresp, rresp;
	wire [3:0] outs; // stage, contactor, unlocked, motor power
	logic fw = 1'b0; // terminal freewheel pin
	logic tune; // self-tuning start pulse
	int tunes = 0; // self-tuning pulses seen
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	dosm_master i_dosm_master (.clk_i(sys_clk_i), .awaddr_o(awa), .awvalid_o(awv),
		.awready_i(awr), .wdata_o(wd), .wvalid_o(wv), .wready_i(wr_rdy), .bresp_i(bresp),
		.bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv), .arready_i(arr),
		.rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));
	// stop key left idle
	dosm_top i_dosm_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rr), .power_supply_ok_i(pwr_ok), .error_detect_i(err),
		.freewheel_in_i(fw), .stop_key_i(1'b0), .power_stage_en_o(outs[3]),
		.contactor_o(outs[2]), .drive_unlocked_o(outs[1]), .motor_power_o(outs[0]),
		.autotune_start_o(tune));
	// count self-tuning pulses, each stands one cycle
	always @(posedge sys_clk_i) begin
		if (tune === 1'b1) tunes++;
	end
	// ----------------------------------------
	// compare and helper tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write and compare the response code
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		i_dosm_master.wr(a, d, r);
		chk(32'(r), 32'(e));
	endtask
	// poll the state code, bounded; ramps take up to a thousand cycles
	task automatic st(input logic [3:0] s, input logic [3:0] o);
		logic [31:0] d;
		for (int i = 0; i < 500; i++) begin
			i_dosm_master.rd(ADDR_STATUS, d);
			if (d[3:0] === s) break;
		end
		repeat (3) @(posedge sys_clk_i);
		chk(32'(d[3:0]), 32'(s));
		chk(32'(outs), 32'(o));
	endtask
	task automatic complete_run();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 12000) begin
			fail_count++;
			complete_run();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_init();
		logic [31:0] d;
		i_dosm_master.rd(ADDR_STATUS, d);
		chk(32'(d[3:0]), 32'h0);
		st(4'h2, 4'h0);
	endtask
	task automatic t_arm();
		wrc(ADDR_CFG, 32'hC, RESP_OKAY);
		wrc(ADDR_CTRL, 32'h6, RESP_OKAY);
		st(4'h3, 4'h0);
		wrc(ADDR_CTRL, 32'h7, RESP_OKAY);
		st(4'h3, 4'h0);
		@(posedge sys_clk_i) pwr_ok <= 1'b1;
		st(4'h4, 4'hC);
		wrc(ADDR_CTRL, 32'hF, RESP_OKAY);
		st(4'h4, 4'hC);
	endtask
	task automatic t_run();
		wrc(ADDR_TUNE, 32'h1, RESP_SLVERR);
		wrc(ADDR_CFG, 32'h4, RESP_OKAY);
		st(4'h2, 4'h0);
		wrc(ADDR_CTRL, 32'h6, RESP_OKAY);
		wrc(ADDR_CTRL, 32'h7, RESP_OKAY);
		wrc(ADDR_REF, 32'h100, RESP_OKAY);
		wrc(ADDR_CTRL, 32'hF, RESP_OKAY);
		st(4'h5, 4'hF);
		wrc(ADDR_CFG, 32'h0, RESP_SLVERR);
		wrc(ADDR_TUNE, 32'h1, RESP_OKAY);
		wrc(ADDR_CTRL, 32'h10F, RESP_OKAY);
		st(4'h5, 4'hE);
		chk(32'(tunes), 32'h1);
		wrc(ADDR_CTRL, 32'h7, RESP_OKAY);
		st(4'h4, 4'hC);
	endtask
	task automatic t_qstop();
		wrc(ADDR_CTRL, 32'hF, RESP_OKAY);
		st(4'h5, 4'hF);
		wrc(ADDR_CTRL, 32'hB, RESP_OKAY);
		st(4'h6, 4'hF);
		wrc(ADDR_CFG, 32'h4, RESP_SLVERR);
		st(4'h2, 4'h0);
	endtask
	// ramp stop, then stop-and-hold left by the freewheel pin
	task automatic t_hold();
		wrc(ADDR_CFG, 32'h7, RESP_OKAY);
		wrc(ADDR_CTRL, 32'h6, RESP_OKAY);
		wrc(ADDR_CTRL, 32'h7, RESP_OKAY);
		wrc(ADDR_CTRL, 32'hF, RESP_OKAY);
		st(4'h5, 4'hF);
		wrc(ADDR_CTRL, 32'h7, RESP_OKAY);
		st(4'h5, 4'hF);
		st(4'h4, 4'hC);
		wrc(ADDR_CTRL, 32'hF, RESP_OKAY);
		st(4'h5, 4'hF);
		wrc(ADDR_CTRL, 32'hB, RESP_OKAY);
		repeat (300) @(posedge sys_clk_i);
		st(4'h6, 4'hF);
		@(posedge sys_clk_i) fw <= 1'b1;
		st(4'h2, 4'h0);
		@(posedge sys_clk_i) fw <= 1'b0;
	endtask
	task automatic t_fault();
		@(posedge sys_clk_i) err <= 1'b1;
		st(4'h8, 4'h0);
		@(posedge sys_clk_i) err <= 1'b0;
		wrc(ADDR_CTRL, 32'h80, RESP_OKAY);
		st(4'h2, 4'h0);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_init();
		t_arm();
		t_run();
		t_qstop();
		t_hold();
		t_fault();
		complete_run();
	end
endmodule
`default_nettype wire

// >>> common/dosm_pkg.sv
package dosm_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 125; // system clock rate
	localparam int unsigned INIT_TIME_NS = 1000; // initialization time
	localparam int unsigned RAMP_TIME_NS = 8000; // normal ramp stop time
	localparam int unsigned FAST_TIME_NS = 2000; // fast stop ramp time
	localparam int unsigned REACT_TIME_NS = 1000; // error response time
	localparam int unsigned INIT_CYC = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RAMP_CYC = (RAMP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned FAST_CYC = (FAST_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned REACT_CYC = (REACT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TMR_W = 12; // timer width
	localparam logic [11:0] INIT_CNT = 12'(INIT_CYC);
	localparam logic [11:0] RAMP_CNT = 12'(RAMP_CYC);
	localparam logic [11:0] FAST_CNT = 12'(FAST_CYC);
	localparam logic [11:0] REACT_CNT = 12'(REACT_CYC);
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00; // control word
	localparam logic [7:0] ADDR_STATUS = 8'h04; // drive_status_word
	localparam logic [7:0] ADDR_CFG = 8'h08; // configuration parameters
	localparam logic [7:0] ADDR_ADJ = 8'h0C; // adjustment parameter
	localparam logic [7:0] ADDR_REF = 8'h10; // speed reference
	localparam logic [7:0] ADDR_TUNE = 8'h14; // self-tuning start
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CW_SWITCH_ON = 0;
	localparam int unsigned CW_EN_VOLT = 1;
	localparam int unsigned CW_QSTOP_N = 2; // 0 asks for quick stop
	localparam int unsigned CW_EN_OP = 3;
	localparam int unsigned CW_FRESET = 7;
	localparam int unsigned CW_HALT = 8;
	localparam int unsigned CW_FREEWHEEL = 12; // assignable bit
	localparam int unsigned CFG_DIS_STOP = 0; // disable_op_stop_select
	localparam int unsigned CFG_QS_HOLD = 1; // quick_stop_behaviour
	localparam int unsigned CFG_CONTACTOR = 2; // contactor control used
	localparam int unsigned CFG_REF_CHAN = 3; // channel carries reference
	// ------------------------------------------------------------
	// reset values and responses
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [3:0] CFG_RST = 4'h0;
	localparam logic [15:0] ADJ_RST = 16'h0000;
	localparam logic [15:0] REF_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {
		ST_NOT_READY,
		ST_SW_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QUICK_STOP,
		ST_FAULT_REACT,
		ST_FAULT
	} dosm_state_type;
endpackage

// >>> logic/dosm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for asynchronous pins
module dosm_sync #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg; // first stage, read by second only

	// ------------------------------------------------------------
	// two stages
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> logic/dosm_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter, one-cycle pulse when a loaded count has run out
module dosm_timer
	import dosm_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [TMR_W-1:0] count_i,
	output logic expired_o
);
	logic [TMR_W-1:0] cnt_reg; // cycles left, zero when idle

	// ------------------------------------------------------------
	// count; a new start overrides a running count
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			expired_o <= 1'b0;
		end else if (start_i) begin
			cnt_reg <= count_i;
			expired_o <= 1'b0;
		end else begin
			// pulse in the cycle the last count is used up
			expired_o <= (cnt_reg == TMR_W'(1));
			if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - TMR_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/dosm_top.sv
// Notes on behaviour
// R1: initialization state is transient, never reported
// R2: state 2: not ready, locked, no power
// R3: states 2 and 3 accept all parameter writes
// R4: state 3 waits for supply before state 4
// R5: contactor open in states 2 and 3
// R6: state 4: power stage on, contactor closed, locked
// R7: state 4: configuration write returns to state 2
// R8: state 5 unlocks, rejects configuration writes
// R9: zero reference or halt removes motor power
// R10: self-tuning starts only in state 5
// R11: enable operation needs valid channel, reference seen
// R12: stop select 0: state 4 at once, coast
// R13: stop select 1: ramp down, then state 4
// R14: quick stop powered, blocks configuration writes
// R15: stop-then-disable: fast ramp, then state 2
// R16: stop-and-hold: stay until disable, key, freewheel
// R17: error enters reaction state, then fault state
// R18: fault state: power stage off, locked
// R19: state changes on commands or events; status shows
// R20: fault reset acts on rising edge only
// R21: freewheel request moves to state 2
// R22: halt keeps state 5 whatever stop type
// R23: state register three bits, resets to state 1
// R24: fault beats disable voltage and freewheel, which beat quick stop, which beats other commands
`timescale 1ns/1ps
`default_nettype none
module dosm_top
	import dosm_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic power_supply_ok_i,
	input wire logic error_detect_i,
	input wire logic freewheel_in_i,
	input wire logic stop_key_i,
	output logic power_stage_en_o,
	output logic contactor_o,
	output logic drive_unlocked_o,
	output logic motor_power_o,
	output logic autotune_start_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	dosm_state_type state_reg; // operating state
	dosm_state_type state_next;
	logic ramp_reg; // ramp stop before state 4
	logic ramp_next;
	logic boot_reg; // first cycle after reset
	logic [15:0] ctrl_reg; // control word
	logic [3:0] cfg_reg; // configuration parameters
	logic [15:0] adj_reg; // adjustment parameter
	logic [15:0] ref_reg; // speed reference
	logic ref_seen_reg; // reference written at least once
	logic freset_prev_reg; // fault reset bit, last cycle
	logic [9:0] status_reg; // drive_status_word
	logic [3:0] st_code; // visible state number
	logic aw_held_reg; // write address taken
	logic w_held_reg; // write data taken
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire; // both halves present, perform write
	logic wr_ok; // write accepted
	logic [1:0] wr_resp;
	logic cfg_wr; // accepted configuration write
	logic cfg_locked; // configuration writes refused
	logic tmr_start;
	logic [TMR_W-1:0] tmr_count;
	logic tmr_done;
	logic [3:0] pin_s; // synchronised pins
	logic pwr_ok_s;
	logic err_s;
	logic fw_pin_s;
	logic key_s;
	logic so_cmd; // switch on
	logic ev_cmd; // enable voltage
	logic qs_n_cmd; // low for quick stop
	logic eo_cmd; // enable operation
	logic halt_cmd;
	logic fw_req; // freewheel from pin or control word
	logic fr_edge; // fault reset rising edge
	logic chan_ok; // commanding channel valid

	// ------------------------------------------------------------
	// pin synchronisers and timer
	// ------------------------------------------------------------
	dosm_sync #(.W(4)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({stop_key_i, freewheel_in_i, error_detect_i, power_supply_ok_i}),
		.q_o(pin_s)
	);
	assign pwr_ok_s = pin_s[0];
	assign err_s = pin_s[1];
	assign fw_pin_s = pin_s[2];
	assign key_s = pin_s[3];

	// one timer serves init, ramps and error response; states never overlap
	dosm_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(tmr_start),
		.count_i(tmr_count),
		.expired_o(tmr_done)
	);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	assign so_cmd = ctrl_reg[CW_SWITCH_ON];
	assign ev_cmd = ctrl_reg[CW_EN_VOLT];
	assign qs_n_cmd = ctrl_reg[CW_QSTOP_N];
	assign eo_cmd = ctrl_reg[CW_EN_OP];
	assign halt_cmd = ctrl_reg[CW_HALT];
	assign fw_req = fw_pin_s | ctrl_reg[CW_FREEWHEEL];
	assign fr_edge = ctrl_reg[CW_FRESET] & ~freset_prev_reg; // R20
	// reference must have arrived if this channel carries it
	assign chan_ok = ~cfg_reg[CFG_REF_CHAN] | ref_seen_reg; // R11

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		ramp_next = ramp_reg;
		tmr_start = boot_reg;
		tmr_count = INIT_CNT;
		case (state_reg)
			ST_NOT_READY: begin
				// leaves on its own once init time is up
				if (tmr_done) begin
					state_next = ST_SW_DISABLED; // R1
				end
			end
			ST_FAULT_REACT: begin
				if (tmr_done) begin
					state_next = ST_FAULT; // R17
				end
			end
			ST_FAULT: begin
				// reset only once the cause has gone
				if (fr_edge && !err_s) begin
					state_next = ST_SW_DISABLED; // R20
				end
			end
			default: begin
				if (err_s) begin
					// fault takes precedence over any command
					state_next = ST_FAULT_REACT; // R17 R24
					tmr_start = 1'b1;
					tmr_count = REACT_CNT;
				end else begin
					case (state_reg)
						ST_SW_DISABLED: begin
							// shutdown command
							if (ev_cmd && qs_n_cmd && !so_cmd && !fw_req) begin
								state_next = ST_READY;
							end
						end
						ST_READY: begin
							if (!ev_cmd || !qs_n_cmd || fw_req) begin
								state_next = ST_SW_DISABLED; // R21
							end else if (so_cmd && pwr_ok_s) begin
								state_next = ST_SWITCHED_ON; // R4
							end
						end
						ST_SWITCHED_ON: begin
							if (!ev_cmd || !qs_n_cmd || fw_req || cfg_wr) begin
								state_next = ST_SW_DISABLED; // R7 R21
							end else if (!so_cmd) begin
								state_next = ST_READY;
							end else if (eo_cmd && chan_ok) begin
								state_next = ST_OP_ENABLED; // R11
							end
						end
						ST_OP_ENABLED: begin
							if (!ev_cmd || fw_req) begin
								state_next = ST_SW_DISABLED; // R21
							end else if (!qs_n_cmd) begin
								state_next = ST_QUICK_STOP; // R24
								tmr_start = 1'b1;
								tmr_count = FAST_CNT;
							end else if (!so_cmd) begin
								state_next = ST_READY;
							end else if (ramp_reg) begin
								if (tmr_done) begin
									state_next = ST_SWITCHED_ON; // R13
								end
							end else if (!eo_cmd) begin
								if (cfg_reg[CFG_DIS_STOP]) begin
									ramp_next = 1'b1; // R13
									tmr_start = 1'b1;
									tmr_count = RAMP_CNT;
								end else begin
									state_next = ST_SWITCHED_ON; // R12
								end
							end
						end
						ST_QUICK_STOP: begin
							if (!ev_cmd || fw_req || key_s) begin
								state_next = ST_SW_DISABLED; // R16
							end else if (tmr_done && !cfg_reg[CFG_QS_HOLD]) begin
								state_next = ST_SW_DISABLED; // R15
							end
						end
						default: begin
							state_next = state_reg;
						end
					endcase
				end
			end
		endcase
		// ramp flag only lives inside state 5
		if (state_next != ST_OP_ENABLED) begin
			ramp_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_NOT_READY; // R23
			ramp_reg <= 1'b0;
			boot_reg <= 1'b1;
			freset_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next; // R19
			ramp_reg <= ramp_next;
			boot_reg <= 1'b0;
			freset_prev_reg <= ctrl_reg[CW_FRESET];
		end
	end

	// ------------------------------------------------------------
	// power outputs, one cycle behind the state
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			power_stage_en_o <= 1'b0;
			contactor_o <= 1'b0;
			drive_unlocked_o <= 1'b0;
			motor_power_o <= 1'b0;
		end else begin
			// off in states 1, 2, 3, 7, 8
			power_stage_en_o <= state_reg inside {ST_SWITCHED_ON, ST_OP_ENABLED,
				ST_QUICK_STOP}; // R2 R6 R18
			contactor_o <= cfg_reg[CFG_CONTACTOR] && (state_reg inside
				{ST_SWITCHED_ON, ST_OP_ENABLED, ST_QUICK_STOP}); // R5 R6
			drive_unlocked_o <= state_reg inside {ST_OP_ENABLED,
				ST_QUICK_STOP}; // R8 R14
			// quick stop keeps power for the fast ramp
			motor_power_o <= (state_reg == ST_QUICK_STOP) ||
				((state_reg == ST_OP_ENABLED) && !halt_cmd &&
				(ref_reg != 16'h0000)); // R9 R22
		end
	end

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	always_comb begin
		case (state_reg)
			ST_NOT_READY: st_code = 4'h0; // hidden while initialising
			ST_SW_DISABLED: st_code = 4'h2;
			ST_READY: st_code = 4'h3;
			ST_SWITCHED_ON: st_code = 4'h4;
			ST_OP_ENABLED: st_code = 4'h5;
			ST_QUICK_STOP: st_code = 4'h6;
			ST_FAULT_REACT: st_code = 4'h7;
			ST_FAULT: st_code = 4'h8;
			default: st_code = 4'h0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			status_reg <= 10'h000;
		end else begin
			status_reg <= {motor_power_o, contactor_o, halt_cmd, pwr_ok_s,
				ref_seen_reg, ramp_reg, st_code}; // R1 R19
		end
	end

	// ------------------------------------------------------------
	// axi write channels
	// ------------------------------------------------------------
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
	assign wr_ok = wr_fire && (wr_resp == RESP_OKAY);
	// configuration locked while running, stopping or reacting
	assign cfg_locked = state_reg inside {ST_OP_ENABLED, ST_QUICK_STOP,
		ST_FAULT_REACT}; // R8 R14

	// decode and answer for the pending write
	always_comb begin
		wr_resp = RESP_OKAY;
		cfg_wr = 1'b0;
		case (awaddr_reg)
			ADDR_CTRL, ADDR_ADJ, ADDR_REF: begin
				wr_resp = RESP_OKAY; // adjustment always accepted
			end
			ADDR_CFG: begin
				if (cfg_locked) begin
					wr_resp = RESP_SLVERR;
				end else begin
					cfg_wr = wr_fire; // R3
				end
			end
			ADDR_TUNE: begin
				if (state_reg != ST_OP_ENABLED) begin
					wr_resp = RESP_SLVERR; // R10
				end
			end
			ADDR_STATUS: begin
				wr_resp = RESP_SLVERR; // read only
			end
			default: begin
				wr_resp = RESP_DECERR;
			end
		endcase
	end

	// address and data accepted in either order
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_held_reg <= 1'b0;
			s_axi_awready_o <= 1'b1;
			awaddr_reg <= 8'h00;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_reg <= 1'b1;
			s_axi_awready_o <= 1'b0;
			awaddr_reg <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_awready_o <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			w_held_reg <= 1'b0;
			s_axi_wready_o <= 1'b1;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_reg <= 1'b1;
			s_axi_wready_o <= 1'b0;
			wdata_reg <= s_axi_wdata_i;
			wstrb_reg <= s_axi_wstrb_i;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_wready_o <= 1'b1;
		end
	end

	// response held until the master takes it
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_resp;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// software registers, byte lanes honoured
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= CTRL_RST;
			cfg_reg <= CFG_RST;
			adj_reg <= ADJ_RST;
			ref_reg <= REF_RST;
			ref_seen_reg <= 1'b0;
		end else if (wr_ok) begin
			for (int b = 0; b < 2; b++) begin
				if (wstrb_reg[b]) begin
					case (awaddr_reg)
						ADDR_CTRL: ctrl_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
						ADDR_ADJ: adj_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
						ADDR_REF: ref_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
						default: begin
						end
					endcase
				end
			end
			if (cfg_wr && wstrb_reg[0]) begin
				cfg_reg <= wdata_reg[3:0]; // R3 R7
			end
			if (awaddr_reg == ADDR_REF) begin
				ref_seen_reg <= 1'b1; // R11
			end
		end
	end

	// self-tuning start pulse
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			autotune_start_o <= 1'b0;
		end else begin
			autotune_start_o <= wr_ok && (awaddr_reg == ADDR_TUNE) &&
				wdata_reg[0]; // R10
		end
	end

	// ------------------------------------------------------------
	// axi read channel
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= RESP_OKAY;
			case (s_axi_araddr_i)
				ADDR_CTRL: s_axi_rdata_o <= {16'h0000, ctrl_reg};
				ADDR_STATUS: s_axi_rdata_o <= {22'h000000, status_reg};
				ADDR_CFG: s_axi_rdata_o <= {28'h0000000, cfg_reg};
				ADDR_ADJ: s_axi_rdata_o <= {16'h0000, adj_reg};
				ADDR_REF: s_axi_rdata_o <= {16'h0000, ref_reg};
				ADDR_TUNE: s_axi_rdata_o <= 32'h0000_0000;
				default: begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_init_hidden: assert property (status_reg[3:0] != 4'h1) // R1
		else $error("state 1 reported in status");
	a_off_unpowered: assert property (motor_power_o |->
		$past(state_reg) inside {ST_OP_ENABLED, ST_QUICK_STOP}) // R2 R18
		else $error("motor powered outside states 5 and 6");
	a_contactor_open: assert property ((state_reg inside {ST_SW_DISABLED,
		ST_READY}) |=> !contactor_o) // R5
		else $error("contactor closed in state 2 or 3");
	a_cfg_reject: assert property ((wr_fire && awaddr_reg == ADDR_CFG &&
		cfg_locked) |=> s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR) // R8
		else $error("configuration write not refused");
	a_cfg_to_off: assert property ((state_reg == ST_SWITCHED_ON && cfg_wr
		&& !err_s) |=> state_reg == ST_SW_DISABLED) // R7
		else $error("configuration write left state 4");
	a_coast_stop: assert property ((state_reg == ST_OP_ENABLED && !err_s &&
		ev_cmd && qs_n_cmd && so_cmd && !fw_req && !ramp_reg && !eo_cmd &&
		!cfg_reg[CFG_DIS_STOP]) |=> state_reg == ST_SWITCHED_ON) // R12
		else $error("coast stop did not reach state 4");
	a_ramp_stop: assert property ((state_reg == ST_OP_ENABLED && ramp_reg && !tmr_done &&
		!err_s && ev_cmd && qs_n_cmd && so_cmd && !fw_req) |=> state_reg == ST_OP_ENABLED) // R13
		else $error("ramp stop left state 5 too early");
	a_fault_first: assert property ((err_s && !(state_reg inside
		{ST_NOT_READY, ST_FAULT_REACT, ST_FAULT})) |=>
		state_reg == ST_FAULT_REACT) // R24
		else $error("fault not given precedence");
	a_halt_nopower: assert property ((state_reg == ST_OP_ENABLED &&
		halt_cmd) |=> !motor_power_o) // R9
		else $error("motor powered under halt");
	a_tune_gate: assert property (autotune_start_o |->
		$past(state_reg) == ST_OP_ENABLED) // R10
		else $error("self-tuning started outside state 5");
endmodule
`default_nettype wire
